// ===== src/clw_defines.svh
// register offsets, field positions, reset values and timing counts of the link watchdog
`ifndef CLW_DEFINES_SVH
`define CLW_DEFINES_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLW_CLK_PERIOD_NS  4
`define CLW_MS_NS          1000000
`define CLW_MS_CYC         (`CLW_MS_NS / `CLW_CLK_PERIOD_NS)
`define CLW_TURN_NS        10000
`define CLW_TURN_CYC       ((`CLW_TURN_NS + `CLW_CLK_PERIOD_NS - 1) / `CLW_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CLW_OFS_CTRL       8'h00
`define CLW_OFS_TIMEOUT    8'h04
`define CLW_OFS_RECOVERY   8'h08
`define CLW_OFS_STATUS     8'h0c
`define CLW_OFS_FLAG_CLR   8'h10
`define CLW_OFS_IRQ_STAT   8'h14
`define CLW_OFS_IRQ_CLR    8'h18
`define CLW_OFS_IRQ_EN     8'h1c

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CLW_CTRL_PROTO_LSB 0
`define CLW_CTRL_POLICY    4
`define CLW_CTRL_TURN_EN   5
`define CLW_CTRL_TSCL_LSB  6
`define CLW_STAT_FLAG      0
`define CLW_STAT_LINK_LSB  1
`define CLW_IRQ_SET        0
`define CLW_IRQ_CLEAR      1
`define CLW_IRQ_LINK       2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CLW_RST_PROTO      4'h0
`define CLW_RST_TIMEOUT    16'h0000
`define CLW_RST_RECOVERY   16'h0000

`endif

// ===== src/clw_pkg.sv
// types shared by the link watchdog modules
package clw_pkg;

    typedef enum logic [3:0] {
        CLW_PROTO_NONE      = 4'h0,
        CLW_PROTO_RTU_SLV   = 4'h1,
        CLW_PROTO_BISYNC    = 4'h2,
        CLW_PROTO_RTU_MST   = 4'h3,
        CLW_PROTO_ETH_NONE  = 4'ha,
        CLW_PROTO_TCP       = 4'hb,
        CLW_PROTO_IND_TCP   = 4'hc,
        CLW_PROTO_BLDG      = 4'hd,
        CLW_PROTO_TCP_MS    = 4'hf
    } clw_proto_e;

    typedef enum logic [1:0] {
        CLW_LINK_OFFLINE  = 2'b00,
        CLW_LINK_INIT     = 2'b01,
        CLW_LINK_ONE_CONN = 2'b10,
        CLW_LINK_READY    = 2'b11
    } clw_link_e;

    typedef enum logic {
        CLW_POL_MANUAL = 1'b0,
        CLW_POL_AUTO   = 1'b1
    } clw_policy_e;

    typedef enum logic [1:0] {
        CLW_TS_MS  = 2'b00,
        CLW_TS_SEC = 2'b01,
        CLW_TS_MIN = 2'b10,
        CLW_TS_HR  = 2'b11
    } clw_tscale_e;

    typedef enum logic [1:0] {
        CLW_WD_WATCH   = 2'b00,
        CLW_WD_FLAGGED = 2'b01,
        CLW_WD_RECOV   = 2'b10
    } clw_wd_e;

endpackage

// ===== src/clw_ta_if.sv
// carrier between the watchdog core and its turnaround delay unit
`timescale 1ns/10ps
interface clw_ta_if;
    logic en;
    logic rx_end;
    logic tx_req;
    logic tx_start;

    modport ctl (output en, output rx_end, output tx_req, input tx_start);
    modport ta  (input en, input rx_end, input tx_req, output tx_start);
endinterface

// ===== src/clw_turnaround.sv
// receive-to-transmit turnaround delay unit
`timescale 1ns/10ps
`include "clw_defines.svh"
module clw_turnaround #(
    parameter int TURN_CYC = `CLW_TURN_CYC
) (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic ce,
    clw_ta_if.ta      ta
);
    localparam int CW = $clog2(TURN_CYC + 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          pend;
    logic          next_pend;
    logic          start;
    logic          next_start;
    logic          go;

    assign ta.tx_start = start;

    // ----------------------------------------------------------------
    // gap counter and start decision
    // ----------------------------------------------------------------
    always_comb begin
        next_cnt = cnt;
        if (ta.rx_end) begin
            next_cnt = '0;
        end else if (cnt != CW'(TURN_CYC)) begin
            next_cnt = cnt + CW'(1);
        end
        // a transmit never starts in the cycle reception ends
        go         = (pend | ta.tx_req) & ~ta.rx_end & (~ta.en | cnt == CW'(TURN_CYC));
        next_start = go;
        next_pend  = (pend | ta.tx_req) & ~go;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt   <= CW'(TURN_CYC);
            pend  <= 1'b0;
            start <= 1'b0;
        end else if (ce) begin
            cnt   <= next_cnt;
            pend  <= next_pend;
            start <= next_start;
        end
    end

    a_turn_gap_held: assert property (@(posedge core_clk) disable iff (!arst_n)
        ce && ta.en && ta.rx_end |=> !ta.tx_start [*2])
        else $error("transmit started inside the turnaround gap");

endmodule

// ===== src/clw_top.sv
// link supervision watchdog with protocol, link state and turnaround control
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "clw_defines.svh"

// Summary of operation
// - protocol codes 12, 13 and 15 are accepted for the three network protocol variants.
// - protocol code 1 selects serial slave operation and code 3 serial master operation.
// - link state reads 0 offline, 1 initialising, 3 ready, and 2 is never used here.
// - supervision runs only for the serial and networked register protocols.
// - the flag sets when no addressed message has come for longer than the timeout.
// - a timeout of 0 turns supervision off, and the timeout resets to 0.
// - the clear policy is 0 for manual and 1 for automatic, resetting to manual.
// - under manual policy the flag stays set until software writes it clear or supervision is turned off.
// - under automatic policy a recovery window governs when resumed traffic clears the flag.
// - a recovery window of 0 clears the flag on the first valid message, and resets to 0.
// - a nonzero window clears the flag only after two valid messages inside the window.
// - the flag reads 0 inactive and 1 active, and the status word cannot be written.
// - an enabled turnaround delay holds transmit after reception, for serial protocols only.
// - the time scale select reads 0 ms, 1 s, 2 min, 3 h, resetting to ms.
module clw_top #(
    parameter int MS_CYC   = `CLW_MS_CYC,
    parameter int TURN_CYC = `CLW_TURN_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        msg_valid,
    input  wire logic        rx_end,
    input  wire logic        tx_req,
    input  wire logic        phy_link_up,
    input  wire logic        stack_ready,
    output logic             tx_start,
    output logic             supervision_flag,
    output logic      [1:0]  link_state,
    output logic      [1:0]  time_scale_select,
    output logic             irq
);
    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic proto_legal(input logic [3:0] c);
        return c inside {4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'hc, 4'hd, 4'hf};
    endfunction

    function automatic logic proto_serial(input logic [3:0] c);
        return c inside {clw_pkg::CLW_PROTO_RTU_SLV, clw_pkg::CLW_PROTO_BISYNC,
                         clw_pkg::CLW_PROTO_RTU_MST};
    endfunction

    function automatic logic proto_supervised(input logic [3:0] c);
        return c inside {clw_pkg::CLW_PROTO_RTU_SLV, clw_pkg::CLW_PROTO_RTU_MST,
                         clw_pkg::CLW_PROTO_TCP, clw_pkg::CLW_PROTO_IND_TCP,
                         clw_pkg::CLW_PROTO_TCP_MS};
    endfunction

    function automatic logic proto_network(input logic [3:0] c);
        return c >= 4'ha;
    endfunction

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [3:0]  proto;
    logic [3:0]  next_proto;
    logic        policy;
    logic        next_policy;
    logic        turn_en;
    logic        next_turn_en;
    logic [1:0]  tscale;
    logic [1:0]  next_tscale;
    logic [15:0] timeout;
    logic [15:0] next_timeout;
    logic [15:0] recovery;
    logic [15:0] next_recovery;
    logic [2:0]  irq_en;
    logic [2:0]  next_irq_en;
    logic        wr_ctrl;
    logic        flag_clr_wr;

    assign wr_ctrl     = reg_wr && reg_addr == `CLW_OFS_CTRL;
    assign flag_clr_wr = reg_wr && reg_addr == `CLW_OFS_FLAG_CLR && reg_wdata[0];

    always_comb begin
        next_proto    = proto;
        next_policy   = policy;
        next_turn_en  = turn_en;
        next_tscale   = tscale;
        next_timeout  = timeout;
        next_recovery = recovery;
        next_irq_en   = irq_en;
        if (wr_ctrl) begin
            // unknown protocol codes are dropped, the old selection stays
            if (proto_legal(reg_wdata[`CLW_CTRL_PROTO_LSB +: 4])) begin
                next_proto = reg_wdata[`CLW_CTRL_PROTO_LSB +: 4];
            end
            next_policy  = reg_wdata[`CLW_CTRL_POLICY];
            next_turn_en = reg_wdata[`CLW_CTRL_TURN_EN];
            next_tscale  = reg_wdata[`CLW_CTRL_TSCL_LSB +: 2];
        end
        if (reg_wr && reg_addr == `CLW_OFS_TIMEOUT) begin
            next_timeout = reg_wdata[15:0];
        end
        if (reg_wr && reg_addr == `CLW_OFS_RECOVERY) begin
            next_recovery = reg_wdata[15:0];
        end
        if (reg_wr && reg_addr == `CLW_OFS_IRQ_EN) begin
            next_irq_en = reg_wdata[2:0];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            proto    <= `CLW_RST_PROTO;
            policy   <= clw_pkg::CLW_POL_MANUAL;
            turn_en  <= 1'b0;
            tscale   <= clw_pkg::CLW_TS_MS;
            timeout  <= `CLW_RST_TIMEOUT;
            recovery <= `CLW_RST_RECOVERY;
            irq_en   <= 3'h0;
        end else if (ce) begin
            proto    <= next_proto;
            policy   <= next_policy;
            turn_en  <= next_turn_en;
            tscale   <= next_tscale;
            timeout  <= next_timeout;
            recovery <= next_recovery;
            irq_en   <= next_irq_en;
        end
    end

    assign time_scale_select = tscale;

    // ----------------------------------------------------------------
    // millisecond base and silence timer
    // ----------------------------------------------------------------
    logic [31:0]        pre_cnt;
    logic [31:0]        next_pre_cnt;
    logic               ms_tick;
    logic [15:0]        idle_ms;
    logic [15:0]        next_idle_ms;
    logic [15:0]        win_ms;
    logic [15:0]        next_win_ms;
    logic               wd_on;
    logic               silent;
    clw_pkg::clw_wd_e   wd_st;
    clw_pkg::clw_wd_e   next_wd_st;
    logic               flag;
    logic               next_flag;

    assign ms_tick = pre_cnt == 32'(MS_CYC - 1);
    assign wd_on   = timeout != 16'h0000 && proto_supervised(proto);
    assign silent  = idle_ms > timeout;

    // ----------------------------------------------------------------
    // supervision state machine
    // ----------------------------------------------------------------
    always_comb begin
        next_pre_cnt = ms_tick ? 32'h0 : pre_cnt + 32'h1;
        next_idle_ms = idle_ms;
        if (msg_valid || flag_clr_wr) begin
            next_idle_ms = 16'h0000;
        end else if (ms_tick && idle_ms != 16'hffff) begin
            next_idle_ms = idle_ms + 16'h1;
        end
        next_win_ms = (ms_tick && win_ms != 16'hffff) ? win_ms + 16'h1 : win_ms;
        next_wd_st  = wd_st;
        next_flag   = flag;
        case (wd_st)
            clw_pkg::CLW_WD_WATCH: begin
                if (wd_on && silent && !msg_valid) begin
                    next_wd_st = clw_pkg::CLW_WD_FLAGGED;
                    next_flag  = 1'b1;
                end
            end
            clw_pkg::CLW_WD_FLAGGED: begin
                if (flag_clr_wr) begin
                    next_wd_st = clw_pkg::CLW_WD_WATCH;
                    next_flag  = 1'b0;
                end else if (policy == clw_pkg::CLW_POL_AUTO && msg_valid) begin
                    if (recovery == 16'h0000) begin
                        next_wd_st = clw_pkg::CLW_WD_WATCH;
                        next_flag  = 1'b0;
                    end else begin
                        next_wd_st  = clw_pkg::CLW_WD_RECOV;
                        next_win_ms = 16'h0000;
                    end
                end
            end
            clw_pkg::CLW_WD_RECOV: begin
                if (flag_clr_wr || msg_valid) begin
                    next_wd_st = clw_pkg::CLW_WD_WATCH;
                    next_flag  = 1'b0;
                end else if (ms_tick && win_ms >= recovery) begin
                    // window lapsed with one message; wait for a fresh first one
                    next_wd_st = clw_pkg::CLW_WD_FLAGGED;
                end
            end
            default: begin
                next_wd_st = clw_pkg::CLW_WD_WATCH;
                next_flag  = 1'b0;
            end
        endcase
        // disabling supervision drops a pending flag at once
        if (!wd_on) begin
            next_wd_st = clw_pkg::CLW_WD_WATCH;
            next_flag  = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_cnt <= 32'h0;
            idle_ms <= 16'h0000;
            win_ms  <= 16'h0000;
            wd_st   <= clw_pkg::CLW_WD_WATCH;
            flag    <= 1'b0;
        end else if (ce) begin
            pre_cnt <= next_pre_cnt;
            idle_ms <= next_idle_ms;
            win_ms  <= next_win_ms;
            wd_st   <= next_wd_st;
            flag    <= next_flag;
        end
    end

    assign supervision_flag = flag;

    // ----------------------------------------------------------------
    // link state
    // ----------------------------------------------------------------
    clw_pkg::clw_link_e link;
    clw_pkg::clw_link_e next_link;

    always_comb begin
        if (!proto_network(proto) || !phy_link_up) begin
            next_link = clw_pkg::CLW_LINK_OFFLINE;
        end else if (!stack_ready) begin
            next_link = clw_pkg::CLW_LINK_INIT;
        end else begin
            next_link = clw_pkg::CLW_LINK_READY;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            link <= clw_pkg::CLW_LINK_OFFLINE;
        end else if (ce) begin
            link <= next_link;
        end
    end

    assign link_state = link;

    // ----------------------------------------------------------------
    // interrupts and register reads
    // ----------------------------------------------------------------
    logic [2:0]  irq_stat;
    logic [2:0]  next_irq_stat;
    logic [2:0]  irq_ev;
    logic [2:0]  irq_clr;
    logic        irq_q;
    logic        next_irq;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    assign irq_ev  = {next_link != link, flag && !next_flag, !flag && next_flag};
    assign irq_clr = (reg_wr && reg_addr == `CLW_OFS_IRQ_CLR) ? reg_wdata[2:0] : 3'h0;

    always_comb begin
        // a new event beats a clear landing in the same cycle
        next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;
        next_irq      = |(next_irq_stat & next_irq_en);
        next_rdata    = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `CLW_OFS_CTRL:     next_rdata = {24'h0, tscale, turn_en, policy, proto};
                `CLW_OFS_TIMEOUT:  next_rdata = {16'h0, timeout};
                `CLW_OFS_RECOVERY: next_rdata = {16'h0, recovery};
                `CLW_OFS_STATUS:   next_rdata = {29'h0, link, flag};
                `CLW_OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
                `CLW_OFS_IRQ_EN:   next_rdata = {29'h0, irq_en};
                default:           next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat <= 3'h0;
            irq_q    <= 1'b0;
            rdata    <= 32'h0;
        end else if (ce) begin
            irq_stat <= next_irq_stat;
            irq_q    <= next_irq;
            rdata    <= next_rdata;
        end
    end

    assign irq       = irq_q;
    assign reg_rdata = rdata;

    // ----------------------------------------------------------------
    // turnaround delay
    // ----------------------------------------------------------------
    clw_ta_if ta_bus ();

    assign ta_bus.en     = turn_en && proto_serial(proto);
    assign ta_bus.rx_end = rx_end;
    assign ta_bus.tx_req = tx_req;
    assign tx_start      = ta_bus.tx_start;

    clw_turnaround #(
        .TURN_CYC (TURN_CYC)
    ) u_turn (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .ta       (ta_bus.ta)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_recov_open;
        ce && wd_st == clw_pkg::CLW_WD_FLAGGED && policy == clw_pkg::CLW_POL_AUTO
            && recovery != 16'h0000 && msg_valid && !flag_clr_wr && wd_on && !wr_ctrl;
    endsequence

    sequence s_second_msg;
        ce && msg_valid && wd_on && !wr_ctrl;
    endsequence

    a_proto_code_12: assert property (wr_ctrl && ce && reg_wdata[3:0] == 4'hc
        |=> proto == 4'hc)
        else $error("protocol code 12 not accepted");
    a_proto_legal: assert property (proto_legal(proto))
        else $error("illegal protocol code held");
    a_link_no_two: assert property (link != clw_pkg::CLW_LINK_ONE_CONN)
        else $error("unused link state reported");
    a_flag_needs_proto: assert property ($rose(flag) |-> $past(proto_supervised(proto)))
        else $error("flag raised on unsupervised protocol");
    a_flag_on_silence: assert property (ce && wd_st == clw_pkg::CLW_WD_WATCH && wd_on
        && silent && !msg_valid && !wr_ctrl |=> flag)
        else $error("flag missed after timeout");
    a_zero_timeout_off: assert property ($rose(flag) |-> $past(timeout) != 16'h0000)
        else $error("flag raised with timeout 0");
    a_manual_flag_hold: assert property (ce && flag && policy == clw_pkg::CLW_POL_MANUAL
        && !flag_clr_wr && wd_on && !wr_ctrl |=> flag)
        else $error("manual flag cleared without write");
    a_first_msg_clear: assert property (ce && wd_st == clw_pkg::CLW_WD_FLAGGED
        && policy == clw_pkg::CLW_POL_AUTO && recovery == 16'h0000 && msg_valid
        |=> !flag)
        else $error("flag not cleared by first message");
    a_two_msg_clear: assert property (s_recov_open ##1 s_second_msg |=> !flag)
        else $error("flag not cleared by second message");
    a_one_msg_keeps: assert property (s_recov_open |=> flag)
        else $error("flag cleared by a single message");
    a_recov_lapse: assert property (ce && wd_st == clw_pkg::CLW_WD_RECOV && ms_tick
        && win_ms >= recovery && !msg_valid && !flag_clr_wr && wd_on
        |=> wd_st == clw_pkg::CLW_WD_FLAGGED && flag)
        else $error("recovery window did not lapse");
    a_status_ro: assert property (ce && reg_wr && reg_addr == `CLW_OFS_STATUS
        && flag && wd_on && !msg_valid |=> flag)
        else $error("status write changed the flag");

endmodule

// ===== verif/clw_master_model.sv
// remote master model: answers each poll request with a frame after a chosen delay
`timescale 1ns/10ps
module clw_master_model (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       poll,
    input  wire logic [7:0] delay,
    output logic            msg_valid,
    output logic            rx_end
);
    logic [8:0] cnt;

    // a frame addressed to this node ends and is valid in the same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt       <= 9'h000;
            msg_valid <= 1'b0;
            rx_end    <= 1'b0;
        end else begin
            if (poll)
                cnt <= {1'b0, delay} + 9'h001;
            else if (cnt != 9'h000)
                cnt <= cnt - 9'h001;
            msg_valid <= (cnt == 9'h001);
            rx_end    <= (cnt == 9'h001);
        end
    end
endmodule

// ===== verif/comms_link_watchdog_bench.sv
// self-checking bench for the link watchdog
`timescale 1ns/10ps
`include "clw_defines.svh"
module comms_link_watchdog_bench;
    localparam int MS = 4;
    localparam int TC = 8;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        tx_req = 1'b0;
    logic        phy_link_up = 1'b0;
    logic        stack_ready = 1'b0;
    logic        poll = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  delay = 8'h00;
    logic [31:0] reg_rdata;
    logic        msg_valid, rx_end, tx_start, supervision_flag, irq;
    logic [1:0]  link_state, time_scale_select;
    int          err_total = 0;
    int          checked = 0;
    int          cycles = 0;

    always #2 core_clk = ~core_clk;

    clw_master_model far (.core_clk(core_clk), .arst_n(arst_n), .poll(poll), .delay(delay),
        .msg_valid(msg_valid), .rx_end(rx_end));
    clw_top #(.MS_CYC(MS), .TURN_CYC(TC)) DUT (.core_clk(core_clk), .arst_n(arst_n),
        .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .msg_valid(msg_valid), .rx_end(rx_end),
        .tx_req(tx_req), .phy_link_up(phy_link_up), .stack_ready(stack_ready),
        .tx_start(tx_start), .supervision_flag(supervision_flag), .link_state(link_state),
        .time_scale_select(time_scale_select), .irq(irq));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic wait_flag(input logic exp, input int n);
        for (int i = 0; i < n && supervision_flag !== exp; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk({31'h0, supervision_flag}, {31'h0, exp});
    endtask
    // waits only until the frame is taken; the timeout bounds a missing frame
    task automatic send(input logic [7:0] d);
        @(posedge core_clk);
        delay <= d;
        poll  <= 1'b1;
        @(posedge core_clk);
        poll  <= 1'b0;
        while (!msg_valid) @(posedge core_clk);
        @(posedge core_clk);
    endtask
    task automatic link_to(input logic p, input logic s, input logic [1:0] exp);
        @(posedge core_clk);
        phy_link_up <= p;
        stack_ready <= s;
        repeat (4) @(posedge core_clk);
        #1 chk({30'h0, link_state}, {30'h0, exp});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(`CLW_OFS_CTRL, 32'h0);
        rd(`CLW_OFS_TIMEOUT, 32'h0);
        rd(`CLW_OFS_RECOVERY, 32'h0);
        rd(`CLW_OFS_STATUS, 32'h0);
        rd(8'h40, 32'h0);
    endtask
    task automatic t_codes();
        logic [3:0] codes [5] = '{4'h1, 4'h3, 4'hc, 4'hd, 4'hf};
        for (int i = 0; i < 5; i++) begin
            wr(`CLW_OFS_CTRL, {24'h0, 2'(i), 2'b00, codes[i]});
            rd(`CLW_OFS_CTRL, {24'h0, 2'(i), 2'b00, codes[i]});
            chk({30'h0, time_scale_select}, {30'h0, 2'(i)});
        end
        // an unlisted code must leave the last good protocol in place
        wr(`CLW_OFS_CTRL, 32'h4);
        rd(`CLW_OFS_CTRL, 32'hf);
    endtask
    task automatic t_link();
        link_to(1'b1, 1'b0, 2'h1);
        link_to(1'b1, 1'b1, 2'h3);
        // clock enable low must hold the last link state
        @(posedge core_clk);
        ce <= 1'b0;
        link_to(1'b0, 1'b0, 2'h3);
        @(posedge core_clk);
        ce <= 1'b1;
        link_to(1'b0, 1'b0, 2'h0);
    endtask
    task automatic t_manual();
        wr(`CLW_OFS_CTRL, 32'h1);
        wr(`CLW_OFS_IRQ_EN, 32'h1);
        wr(`CLW_OFS_TIMEOUT, 32'h1);
        send(8'h00);
        wait_flag(1'b1, 40);
        repeat (3) @(posedge core_clk);
        #1 chk({31'h0, irq}, 32'h1);
        rd(`CLW_OFS_STATUS, 32'h1);
        wr(`CLW_OFS_STATUS, 32'h0);
        rd(`CLW_OFS_STATUS, 32'h1);
        send(8'h06);
        repeat (4) @(posedge core_clk);
        #1 chk({31'h0, supervision_flag}, 32'h1);
        wr(`CLW_OFS_IRQ_CLR, 32'h1);
        repeat (2) @(posedge core_clk);
        #1 chk({31'h0, irq}, 32'h0);
        wr(`CLW_OFS_FLAG_CLR, 32'h1);
        wait_flag(1'b0, 3);
        // idle count cannot pass the timeout this soon after the clear
        repeat (3) @(posedge core_clk);
        #1 chk({31'h0, supervision_flag}, 32'h0);
        wait_flag(1'b1, 40);
        wr(`CLW_OFS_TIMEOUT, 32'h0);
        wait_flag(1'b0, 3);
        repeat (40) @(posedge core_clk);
        #1 chk({31'h0, supervision_flag}, 32'h0);
    endtask
    task automatic t_auto();
        wr(`CLW_OFS_CTRL, 32'h1c);
        wr(`CLW_OFS_TIMEOUT, 32'h1);
        wait_flag(1'b1, 40);
        send(8'h00);
        wait_flag(1'b0, 3);
        wr(`CLW_OFS_RECOVERY, 32'h5);
        wait_flag(1'b1, 40);
        // one message, then let the window lapse: the flag must stay
        send(8'h00);
        repeat (30) @(posedge core_clk);
        #1 chk({31'h0, supervision_flag}, 32'h1);
        send(8'h00);
        repeat (3) @(posedge core_clk);
        #1 chk({31'h0, supervision_flag}, 32'h1);
        send(8'h02);
        wait_flag(1'b0, 3);
    endtask
    task automatic t_turn(input logic en);
        int n;
        wr(`CLW_OFS_TIMEOUT, 32'h0);
        wr(`CLW_OFS_CTRL, en ? 32'h21 : 32'h01);
        @(posedge core_clk);
        poll <= 1'b1;
        @(posedge core_clk);
        poll <= 1'b0;
        while (!rx_end) @(posedge core_clk);
        tx_req <= 1'b1;
        @(posedge core_clk);
        tx_req <= 1'b0;
        n = 1;
        while (!tx_start && n < 60) begin
            @(posedge core_clk);
            n++;
        end
        chk({31'h0, en ? (n >= TC + 2 && n <= TC + 5) : (n <= 4)}, 32'h1);
    endtask

    task automatic close_out();
        $display("mismatches %0d, comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            $display("unexpected at %0t: run timed out", $time);
            close_out();
        end
    end

    initial begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_codes();
        t_link();
        t_manual();
        t_auto();
        t_turn(1'b0);
        t_turn(1'b1);
        close_out();
    end
endmodule
